// [verilog/pci_expansion_bus_bridge_regs.svh]
/*
   Register offsets, field positions and reset values of the bridge.
   Assumes a 4-bit byte address.
*/
`ifndef PCI_EXPANSION_BUS_BRIDGE_REGS_SVH
`define PCI_EXPANSION_BUS_BRIDGE_REGS_SVH

// ====
// Register offsets
`define REG_WINDOW_BASE 4'h0
`define REG_COMMAND 4'h4
`define REG_CONFIG 4'h8
`define REG_STATUS 4'hc

// ====
// Field positions
`define WIN_MSB 31
`define WIN_LSB 20
`define LADDR_MSB 19
`define LADDR_LSB 2
`define CMD_MEM_EN_BIT 0
`define CMD_PERR_BIT 1
`define CFG_AHOLD_MSB 1
`define CFG_AHOLD_LSB 0
`define CFG_DHOLD_MSB 4
`define CFG_DHOLD_LSB 2
`define CFG_GAP_MSB 7
`define CFG_GAP_LSB 5
`define CFG_CKEN_BIT 8

// ====
// Reset values
`define WIN_BASE_RST 12'h000
`define AHOLD_RST 2'h0
`define DHOLD_RST 3'h0
`define GAP_RST 3'h0
`define CKEN_RST 1'h1

`endif

// [verilog/pci_expansion_bus_bridge_pkg.sv]
/*
   Types shared by the bridge.
   Assumes nothing of its surroundings.
*/
`default_nettype none

package pci_expansion_bus_bridge_pkg;

   // ====
   // Local bus sequencer states
   typedef enum logic [3:0] {
      L_IDLE, L_REQ, L_PREADDR, L_ADDR, L_POSTADDR,
      L_PREDATA, L_DATA, L_POSTDATA, L_GAP
   } lstate_type;

   // ====
   // Target answer to one PCI data phase
   typedef enum logic [2:0] {
      RESP_NO_CLAIM, RESP_ACK, RESP_ACK_DISC, RESP_RETRY, RESP_DISC
   } resp_type;

endpackage

`default_nettype wire

// [verilog/pci_expansion_bus_bridge.sv]
/*
   PCI target to local expansion bus bridge.
   Assumes clk_sys is the PCI clock and one-cycle PCI phase strobes.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pci_expansion_bus_bridge_regs.svh"

// Overview of operation
// - Forward accesses whose address bits 31:20 equal the window base.
// - Window disabled after reset; such accesses are not claimed.
// - Every local transfer is one dword, never a burst.
// - Write bursts of 1-4 dwords go to a 4-entry buffer; longer disconnect.
// - Burst reads disconnect after the first data phase.
// - Local address 17:0 is PCI address 19:2.
// - All 32 data bits and the four byte enables pass unchanged.
// - Local clock pin toggles every cycle in both modes; fast select halves the local period rate.
// - Local clock pin is released when clock output is disabled.
// - Peripheral interrupt passes through to the PCI interrupt B output.
// - Address stays valid address_hold_extra plus one local periods.
// - Data stays valid data_hold_extra plus one local periods.
// - Fixed pre/post address and pre/post data cycles outside the durations.
// - Wait bus_reacquire_gap plus one local periods before requesting again.
// - Timing counts run on local periods even with clock output disabled.
// - PCI writes complete at once; the local write follows on its own.
// - Reads are retried and start a local read until data has arrived.
// - Ready data returned on matching retry address, else a new local read.
// - Request the bus, wait for grant, drive, then drop the request.
module pci_expansion_bus_bridge #(
   parameter int FIFO_DEPTH = 4,
   parameter int BURST_MAX = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // PCI target data phases
   input wire logic pci_phase_valid,
   input wire logic pci_phase_first,
   input wire logic pci_phase_write,
   input wire logic [31:0] pci_addr,
   input wire logic [3:0] pci_cbe_n,
   input wire logic [31:0] pci_wdata,
   output logic pci_resp_valid,
   output pci_expansion_bus_bridge_pkg::resp_type pci_resp_code,
   output logic [31:0] pci_resp_rdata,
   output logic pci_intb_n,
   // Local expansion bus
   input wire logic fast_pci_select,
   input wire logic peripheral_irq_n,
   input wire logic local_grant_n,
   input wire logic [31:0] local_addr_data_in,
   output logic [31:0] local_addr_data_out,
   output logic local_addr_data_oe,
   output logic [3:0] local_byte_enables_n,
   output logic local_ctrl_oe,
   output logic local_addr_strobe_n,
   output logic local_read_n,
   output logic local_write_n,
   output logic local_request_n,
   output logic local_bus_clock,
   output logic local_bus_clock_oe
);

   localparam int PW = $clog2(FIFO_DEPTH);
   localparam int EW = 54;
   localparam logic [PW:0] FIFO_FULL = (PW+1)'(FIFO_DEPTH);
   localparam logic [2:0] LAST_PHASE = 3'(BURST_MAX - 1);

   typedef struct packed {
      logic [1:0] fast_sync;
      logic [1:0] grant_sync;
      logic [1:0] irq_sync;
      logic [31:0] din_meta;
      logic [31:0] din_sync;
      logic [11:0] win_base;
      logic mem_en;
      logic perr_en;
      logic [1:0] ahold;
      logic [2:0] dhold;
      logic [2:0] gap;
      logic cken;
      logic [31:0] rdata;
      pci_expansion_bus_bridge_pkg::lstate_type lst;
      logic [2:0] cnt;
      logic phase;
      logic clk_out;
      logic op_write;
      logic [FIFO_DEPTH-1:0][EW-1:0] fifo;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] fcount;
      logic [2:0] wr_phase;
      logic [31:0] rd_addr;
      logic [3:0] rd_be;
      logic rd_pending;
      logic rd_inflight;
      logic rd_ready;
      logic [31:0] rd_data;
      logic resp_valid;
      pci_expansion_bus_bridge_pkg::resp_type resp_code;
      logic [31:0] resp_rdata;
      logic intb_n;
      logic [31:0] ad_out;
      logic ad_oe;
      logic [3:0] be_n;
      logic ctrl_oe;
      logic as_n;
      logic rd_n;
      logic wr_n;
      logic req_n;
   } state_type;

   state_type st_r;
   state_type st_nxt;

   // ====
   // Next state of the whole block
   always_comb begin
      logic tick;
      logic hit;
      logic [2:0] idx;
      logic [EW-1:0] ent;
      tick = 1'b0;
      hit = 1'b0;
      idx = 3'h0;
      ent = '0;
      st_nxt = st_r;

      // Pin synchronisers
      st_nxt.fast_sync = {st_r.fast_sync[0], fast_pci_select};
      st_nxt.grant_sync = {st_r.grant_sync[0], local_grant_n};
      st_nxt.irq_sync = {st_r.irq_sync[0], peripheral_irq_n};
      st_nxt.din_meta = local_addr_data_in;
      st_nxt.din_sync = st_r.din_meta;
      st_nxt.intb_n = st_r.irq_sync[1];

      // Local period enable: every cycle, or every other in fast mode
      st_nxt.phase = ~st_r.phase;
      tick = ~st_r.fast_sync[1] | st_r.phase;
      st_nxt.clk_out = st_r.fast_sync[1] ? st_r.phase : ~st_r.clk_out;

      // Register port
      st_nxt.rdata = 32'h0000_0000;
      if (reg_write) begin
         unique case (reg_addr)
            `REG_WINDOW_BASE: st_nxt.win_base = reg_wdata[`WIN_MSB:`WIN_LSB];
            `REG_COMMAND: begin
               st_nxt.mem_en = reg_wdata[`CMD_MEM_EN_BIT];
               st_nxt.perr_en = reg_wdata[`CMD_PERR_BIT];
            end
            `REG_CONFIG: begin
               st_nxt.ahold = reg_wdata[`CFG_AHOLD_MSB:`CFG_AHOLD_LSB];
               st_nxt.dhold = reg_wdata[`CFG_DHOLD_MSB:`CFG_DHOLD_LSB];
               st_nxt.gap = reg_wdata[`CFG_GAP_MSB:`CFG_GAP_LSB];
               st_nxt.cken = reg_wdata[`CFG_CKEN_BIT];
            end
            default: ;
         endcase
      end
      if (reg_read) begin
         unique case (reg_addr)
            `REG_WINDOW_BASE: st_nxt.rdata[`WIN_MSB:`WIN_LSB] = st_r.win_base;
            `REG_COMMAND: begin
               st_nxt.rdata[`CMD_MEM_EN_BIT] = st_r.mem_en;
               st_nxt.rdata[`CMD_PERR_BIT] = st_r.perr_en;
            end
            `REG_CONFIG: begin
               st_nxt.rdata[`CFG_AHOLD_MSB:`CFG_AHOLD_LSB] = st_r.ahold;
               st_nxt.rdata[`CFG_DHOLD_MSB:`CFG_DHOLD_LSB] = st_r.dhold;
               st_nxt.rdata[`CFG_GAP_MSB:`CFG_GAP_LSB] = st_r.gap;
               st_nxt.rdata[`CFG_CKEN_BIT] = st_r.cken;
            end
            `REG_STATUS: begin
               st_nxt.rdata[3:0] = 4'(st_r.fcount);
               st_nxt.rdata[7:4] = st_r.lst;
               st_nxt.rdata[8] = st_r.rd_pending;
               st_nxt.rdata[9] = st_r.rd_ready;
               st_nxt.rdata[10] = st_r.fast_sync[1];
               st_nxt.rdata[11] = ~st_r.grant_sync[1];
            end
            default: ;
         endcase
      end

      // PCI target side: one answer per data phase
      st_nxt.resp_valid = 1'b0;
      if (pci_phase_valid) begin
         hit = st_r.mem_en && (pci_addr[`WIN_MSB:`WIN_LSB] == st_r.win_base);
         st_nxt.resp_valid = 1'b1;
         st_nxt.resp_code = pci_expansion_bus_bridge_pkg::RESP_NO_CLAIM;
         st_nxt.resp_rdata = 32'h0000_0000;
         if (hit && pci_phase_write) begin
            idx = pci_phase_first ? 3'h0 : st_r.wr_phase;
            if (idx > LAST_PHASE) begin
               st_nxt.resp_code = pci_expansion_bus_bridge_pkg::RESP_DISC;
            end else if (st_r.fcount == FIFO_FULL) begin
               st_nxt.resp_code = pci_phase_first ?
                  pci_expansion_bus_bridge_pkg::RESP_RETRY :
                  pci_expansion_bus_bridge_pkg::RESP_DISC;
            end else begin
               // Posted: completes now, local write follows later
               st_nxt.fifo[st_r.wp] = {pci_addr[`LADDR_MSB:`LADDR_LSB], pci_cbe_n,
                                       pci_wdata};
               st_nxt.wp = PW'(st_r.wp + 1'b1);
               st_nxt.fcount = (PW+1)'(st_r.fcount + 1'b1);
               st_nxt.wr_phase = 3'(idx + 3'h1);
               st_nxt.resp_code = (idx == LAST_PHASE) ?
                  pci_expansion_bus_bridge_pkg::RESP_ACK_DISC :
                  pci_expansion_bus_bridge_pkg::RESP_ACK;
            end
         end else if (hit) begin
            if (!pci_phase_first) begin
               st_nxt.resp_code = pci_expansion_bus_bridge_pkg::RESP_DISC;
            end else if (st_r.rd_ready && pci_addr == st_r.rd_addr) begin
               st_nxt.resp_code = pci_expansion_bus_bridge_pkg::RESP_ACK_DISC;
               st_nxt.resp_rdata = st_r.rd_data;
               st_nxt.rd_ready = 1'b0;
               st_nxt.rd_pending = 1'b0;
            end else begin
               st_nxt.resp_code = pci_expansion_bus_bridge_pkg::RESP_RETRY;
               if (!st_r.rd_inflight && !(st_r.rd_pending && pci_addr == st_r.rd_addr)) begin
                  // New or mismatching address starts a fresh local read
                  st_nxt.rd_addr = pci_addr;
                  st_nxt.rd_be = pci_cbe_n;
                  st_nxt.rd_pending = 1'b1;
                  st_nxt.rd_ready = 1'b0;
               end
            end
         end
      end

      // Local bus sequencer, one dword per tenure
      unique case (st_r.lst)
         pci_expansion_bus_bridge_pkg::L_IDLE: begin
            if (st_r.fcount != '0) begin
               ent = st_r.fifo[st_r.rp];
               st_nxt.ad_out = {14'h0000, ent[53:36]};
               st_nxt.be_n = ent[35:32];
               st_nxt.rd_data = ent[31:0];
               st_nxt.rp = PW'(st_r.rp + 1'b1);
               st_nxt.fcount = (PW+1)'(st_nxt.fcount - 1'b1);
               st_nxt.op_write = 1'b1;
               st_nxt.req_n = 1'b0;
               st_nxt.lst = pci_expansion_bus_bridge_pkg::L_REQ;
            end else if (st_r.rd_pending && !st_r.rd_ready) begin
               st_nxt.ad_out = {14'h0000, st_r.rd_addr[`LADDR_MSB:`LADDR_LSB]};
               st_nxt.be_n = st_r.rd_be;
               st_nxt.op_write = 1'b0;
               st_nxt.rd_inflight = 1'b1;
               st_nxt.req_n = 1'b0;
               st_nxt.lst = pci_expansion_bus_bridge_pkg::L_REQ;
            end
         end
         pci_expansion_bus_bridge_pkg::L_REQ: begin
            if (!st_r.grant_sync[1]) begin
               st_nxt.ad_oe = 1'b1;
               st_nxt.ctrl_oe = 1'b1;
               st_nxt.lst = pci_expansion_bus_bridge_pkg::L_PREADDR;
            end
         end
         pci_expansion_bus_bridge_pkg::L_PREADDR: begin
            st_nxt.as_n = 1'b0;
            st_nxt.cnt = 3'h0;
            st_nxt.lst = pci_expansion_bus_bridge_pkg::L_ADDR;
         end
         pci_expansion_bus_bridge_pkg::L_ADDR: begin
            if (tick) begin
               if (st_r.cnt == {1'b0, st_r.ahold}) begin
                  st_nxt.lst = pci_expansion_bus_bridge_pkg::L_POSTADDR;
                  st_nxt.as_n = 1'b1;
               end else begin
                  st_nxt.cnt = 3'(st_r.cnt + 3'h1);
               end
            end
         end
         pci_expansion_bus_bridge_pkg::L_POSTADDR: begin
            // One cycle to turn from address to data
            st_nxt.ad_out = st_r.op_write ? st_r.rd_data : 32'h0000_0000;
            st_nxt.ad_oe = st_r.op_write;
            st_nxt.lst = pci_expansion_bus_bridge_pkg::L_PREDATA;
         end
         pci_expansion_bus_bridge_pkg::L_PREDATA: begin
            st_nxt.wr_n = ~st_r.op_write;
            st_nxt.rd_n = st_r.op_write;
            st_nxt.cnt = 3'h0;
            st_nxt.lst = pci_expansion_bus_bridge_pkg::L_DATA;
         end
         pci_expansion_bus_bridge_pkg::L_DATA: begin
            if (tick) begin
               if (st_r.cnt == st_r.dhold) begin
                  if (!st_r.op_write) begin
                     st_nxt.rd_data = st_r.din_sync;
                  end
                  st_nxt.wr_n = 1'b1;
                  st_nxt.rd_n = 1'b1;
                  st_nxt.lst = pci_expansion_bus_bridge_pkg::L_POSTDATA;
               end else begin
                  st_nxt.cnt = 3'(st_r.cnt + 3'h1);
               end
            end
         end
         pci_expansion_bus_bridge_pkg::L_POSTDATA: begin
            if (tick) begin
               st_nxt.ad_oe = 1'b0;
               st_nxt.ctrl_oe = 1'b0;
               st_nxt.req_n = 1'b1;
               st_nxt.cnt = 3'h0;
               if (!st_r.op_write) begin
                  st_nxt.rd_inflight = 1'b0;
                  st_nxt.rd_ready = st_nxt.rd_pending;
               end
               st_nxt.lst = pci_expansion_bus_bridge_pkg::L_GAP;
            end
         end
         pci_expansion_bus_bridge_pkg::L_GAP: begin
            if (tick) begin
               if (st_r.cnt == st_r.gap) begin
                  st_nxt.lst = pci_expansion_bus_bridge_pkg::L_IDLE;
               end else begin
                  st_nxt.cnt = 3'(st_r.cnt + 3'h1);
               end
            end
         end
         default: st_nxt.lst = pci_expansion_bus_bridge_pkg::L_IDLE;
      endcase
   end

   // ====
   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= '0;
         st_r.grant_sync <= 2'h3;
         st_r.irq_sync <= 2'h3;
         st_r.win_base <= `WIN_BASE_RST;
         st_r.mem_en <= 1'b0;
         st_r.ahold <= `AHOLD_RST;
         st_r.dhold <= `DHOLD_RST;
         st_r.gap <= `GAP_RST;
         st_r.cken <= `CKEN_RST;
         st_r.intb_n <= 1'b1;
         st_r.be_n <= 4'hf;
         st_r.as_n <= 1'b1;
         st_r.rd_n <= 1'b1;
         st_r.wr_n <= 1'b1;
         st_r.req_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ====
   // Outputs, each straight from the state register
   assign reg_rdata = st_r.rdata;
   assign pci_resp_valid = st_r.resp_valid;
   assign pci_resp_code = st_r.resp_code;
   assign pci_resp_rdata = st_r.resp_rdata;
   assign pci_intb_n = st_r.intb_n;
   assign local_addr_data_out = st_r.ad_out;
   assign local_addr_data_oe = st_r.ad_oe;
   assign local_byte_enables_n = st_r.be_n;
   assign local_ctrl_oe = st_r.ctrl_oe;
   assign local_addr_strobe_n = st_r.as_n;
   assign local_read_n = st_r.rd_n;
   assign local_write_n = st_r.wr_n;
   assign local_request_n = st_r.req_n;
   assign local_bus_clock = st_r.clk_out;
   assign local_bus_clock_oe = st_r.cken;

endmodule

`default_nettype wire

// [test/bridge_checker_assertions.sv]
/*
   Port checker of the bridge.
   Assumes settings arrive by the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module bridge_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic pci_phase_valid,
   input wire logic pci_phase_first,
   input wire logic pci_phase_write,
   input wire logic [31:0] pci_addr,
   input wire logic pci_resp_valid,
   input wire pci_expansion_bus_bridge_pkg::resp_type pci_resp_code,
   input wire logic pci_intb_n,
   input wire logic fast_pci_select,
   input wire logic peripheral_irq_n,
   input wire logic local_grant_n,
   input wire logic local_ctrl_oe,
   input wire logic local_addr_strobe_n,
   input wire logic local_read_n,
   input wire logic local_write_n,
   input wire logic local_request_n,
   input wire logic local_bus_clock_oe
);
   // ====
   // Shadow settings and run counters
   logic [11:0] win_r;
   logic mem_r;
   logic ck_r;
   logic [1:0] ah_r;
   logic [2:0] dh_r;
   logic [2:0] gp_r;
   logic [7:0] as_r;
   logic [7:0] ds_r;
   logic [7:0] hi_r;
   logic [1:0] na_r;
   logic ds_n;
   logic [3:0] m;
   logic hit;
   assign ds_n = local_read_n & local_write_n;
   assign m = fast_pci_select ? 4'h2 : 4'h1;
   assign hit = mem_r && pci_addr[31:20] == win_r;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         win_r <= 12'h000;
         mem_r <= 1'b0;
         {ck_r, gp_r, dh_r, ah_r} <= 9'h100;
      end else if (reg_write && reg_addr == 4'h0) begin
         win_r <= reg_wdata[31:20];
      end else if (reg_write && reg_addr == 4'h4) begin
         mem_r <= reg_wdata[0];
      end else if (reg_write && reg_addr == 4'h8) begin
         {ck_r, gp_r, dh_r, ah_r} <= reg_wdata[8:0];
      end
      as_r <= local_addr_strobe_n ? 8'h0 : as_r + 8'h1;
      ds_r <= ds_n ? 8'h0 : ds_r + 8'h1;
      na_r <= local_request_n ? 2'h0 : na_r + 2'($fell(local_addr_strobe_n));
   end
   // Cycles with the request released, saturating
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hi_r <= 8'hff;
      end else if (!local_request_n) begin
         hi_r <= 8'h0;
      end else if (hi_r != 8'hff) begin
         hi_r <= hi_r + 8'h1;
      end
   end
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_resp_delay: assert property (pci_phase_valid |=> pci_resp_valid)
      else $error("answer not one cycle after phase");
   a_miss_no_claim: assert property (pci_phase_valid && mem_r && !hit |=>
      pci_resp_code == pci_expansion_bus_bridge_pkg::RESP_NO_CLAIM) else $error("miss claimed");
   a_off_no_claim: assert property (pci_phase_valid && !mem_r |=>
      pci_resp_code == pci_expansion_bus_bridge_pkg::RESP_NO_CLAIM) else $error("off claimed");
   a_read_burst_disc: assert property (pci_phase_valid && hit && !pci_phase_write &&
      !pci_phase_first |=> pci_resp_code == pci_expansion_bus_bridge_pkg::RESP_DISC)
      else $error("read burst not cut");
   a_single_dword: assert property ($rose(local_request_n) |-> na_r == 2'h1)
      else $error("not one address per tenure");
   a_clock_release: assert property (ck_r == $past(ck_r) && ck_r == $past(ck_r, 2)
      |-> local_bus_clock_oe == ck_r) else $error("clock drive wrong");
   a_irq_pass: assert property (pci_intb_n == $past(peripheral_irq_n, 3))
      else $error("interrupt not passed");
   a_addr_span: assert property ($rose(local_addr_strobe_n) |->
      as_r <= (ah_r + 1) * m && as_r > (ah_r + 1) * m - m) else $error("address span");
   a_data_span: assert property ($rose(ds_n) |->
      ds_r <= (dh_r + 1) * m && ds_r > (dh_r + 1) * m - m) else $error("data span");
   a_fixed_gaps: assert property ($rose(local_addr_strobe_n) |-> ds_n [*2] ##[0:1] !ds_n)
      else $error("pre data wrong");
   a_post_data: assert property ($rose(ds_n) |-> ##[1:2] $rose(local_request_n))
      else $error("post data wrong");
   a_bus_gap: assert property ($fell(local_request_n) |-> hi_r > (gp_r + 1) * m - m)
      else $error("request too soon");
   a_grant_first: assert property ($rose(local_ctrl_oe) |->
      !local_request_n && !$past(local_grant_n, 2)) else $error("drove without grant");
   cover property (pci_resp_valid && pci_resp_code == pci_expansion_bus_bridge_pkg::RESP_RETRY);
   cover property ($fell(local_read_n));
   cover property ($fell(local_write_n) && fast_pci_select);
endmodule
bind pci_expansion_bus_bridge bridge_checker chk_i (.clk_sys, .rst, .reg_addr, .reg_wdata,
   .reg_write, .pci_phase_valid, .pci_phase_first, .pci_phase_write, .pci_addr,
   .pci_resp_valid, .pci_resp_code, .pci_intb_n, .fast_pci_select, .peripheral_irq_n,
   .local_grant_n, .local_ctrl_oe, .local_addr_strobe_n, .local_read_n, .local_write_n,
   .local_request_n, .local_bus_clock_oe);
`default_nettype wire

// [test/local_bus_partner.sv]
/*
   Arbiter and 32-bit peripheral on the local bus.
   Assumes the bridge drives raw pins on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module local_bus_partner #(
   parameter logic [31:0] PAT = 32'h5a5ac3c3
) (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic local_request_n,
   input wire logic local_addr_strobe_n,
   input wire logic [31:0] local_addr_data_out,
   output logic local_grant_n,
   output logic [31:0] local_addr_data_in
);
   // ====
   // Grant after a short or long delay; peripheral answers reads
   logic [2:0] wait_r;
   logic hold_r;
   initial begin
      local_grant_n = 1'b1;
      local_addr_data_in = 32'h0;
      wait_r = 3'h0;
      hold_r = 1'b0;
   end
   always @(posedge clk_sys) begin
      if (local_request_n) begin
         local_grant_n <= 1'b1;
         wait_r <= 3'h0;
      end else if (wait_r >= (slow ? 3'h5 : 3'h1)) begin
         local_grant_n <= 1'b0;
      end else begin
         wait_r <= wait_r + 3'h1;
      end
      hold_r <= !local_request_n && (hold_r || !local_addr_strobe_n);
      if (!local_addr_strobe_n) begin
         local_addr_data_in <= {14'h0, local_addr_data_out[17:0]} ^ PAT;
      end else if (!hold_r) begin
         // Released lines never keep a stale value
         local_addr_data_in <= ~local_addr_data_in;
      end
   end
endmodule
`default_nettype wire

// [test/tb_top.sv]
/*
   Self-checking bench of the bridge.
   Assumes the partner model on the local side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [31:0] PAT = 32'h5a5ac3c3;
   logic clk_sys, rst, reg_write, reg_read, pv, pf, pw, fast, irq_n, slow, gnt_n;
   logic ad_oe, ctrl_oe, as_n, rd_n, wr_n, req_n, lclk, lclk_oe, rvalid, intb_n;
   logic rd_d, as_p, wr_p;
   logic [3:0] reg_addr, be, ben;
   logic [11:0] win;
   logic [8:0] cfg;
   logic [31:0] reg_wdata, reg_rdata, pa, pd, rdata, din, dout, v;
   logic [32:0] rn;
   pci_expansion_bus_bridge_pkg::resp_type rcode;
   logic [32:0] rq[$];
   logic [34:0] pq[$];
   logic [35:0] aq[$];
   logic [31:0] wq[$];
   int failures = 0;
   int num_checks = 0;
   int seed = 32'h05dbd42a;

   pci_expansion_bus_bridge dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .pci_phase_valid(pv), .pci_phase_first(pf),
      .pci_phase_write(pw), .pci_addr(pa), .pci_cbe_n(be), .pci_wdata(pd),
      .pci_resp_valid(rvalid), .pci_resp_code(rcode), .pci_resp_rdata(rdata),
      .pci_intb_n(intb_n), .fast_pci_select(fast), .peripheral_irq_n(irq_n),
      .local_grant_n(gnt_n), .local_addr_data_in(din), .local_addr_data_out(dout),
      .local_addr_data_oe(ad_oe), .local_byte_enables_n(ben), .local_ctrl_oe(ctrl_oe),
      .local_addr_strobe_n(as_n), .local_read_n(rd_n), .local_write_n(wr_n),
      .local_request_n(req_n), .local_bus_clock(lclk), .local_bus_clock_oe(lclk_oe));
   local_bus_partner #(.PAT(PAT)) far (.clk_sys, .slow, .local_request_n(req_n),
      .local_addr_strobe_n(as_n), .local_addr_data_out(dout), .local_grant_n(gnt_n),
      .local_addr_data_in(din));

   // ====
   // Clock, verdict and compare
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic finish_test;
      if (failures == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   // ====
   // Register port and PCI phase drivers
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [32:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      rq.push_back(e);
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // Poll status under a bound until the masked value shows
   task automatic poll(input logic [31:0] mask, input logic [31:0] val);
      int n = 0;
      v = 32'hffffffff;
      while ((v & mask) !== val) begin
         n++;
         if (n > 300) begin
            failures++;
            finish_test();
         end
         reg_rd(4'hc, 33'h0);
      end
   endtask
   task automatic pci(input logic f, input logic w, input logic [31:0] a,
      input pci_expansion_bus_bridge_pkg::resp_type c, input logic [31:0] r, input logic loc);
      logic [31:0] d = $random(seed);
      logic [3:0] b = 4'($random(seed));
      @(posedge clk_sys);
      pv <= 1'b1;
      pf <= f;
      pw <= w;
      pa <= a;
      be <= b;
      pd <= d;
      pq.push_back({c, r});
      if (loc) aq.push_back({14'h0, a[19:2], b});
      if (loc && w) wq.push_back(d);
   endtask
   task automatic pci_end;
      @(posedge clk_sys);
      pv <= 1'b0;
   endtask

   // ====
   // Write burst, split read, retries and a window miss
   task automatic traffic;
      logic [31:0] a = {win, 1'b0, 17'($random(seed)), 2'h0};
      logic [31:0] r = {win, 1'b0, 17'($random(seed)), 2'h0};
      pci_expansion_bus_bridge_pkg::resp_type c = pci_expansion_bus_bridge_pkg::RESP_ACK;
      for (int i = 0; i < 5; i++) begin
         if (i == 3) c = pci_expansion_bus_bridge_pkg::RESP_ACK_DISC;
         if (i == 4) c = pci_expansion_bus_bridge_pkg::RESP_DISC;
         pci(i == 0, 1'b1, a + 32'(4 * i), c, 32'h0, i < 4);
      end
      pci_end();
      poll(32'hff, 32'h0);
      c = pci_expansion_bus_bridge_pkg::RESP_RETRY;
      pci(1'b1, 1'b0, r, c, 32'h0, 1'b1);
      pci(1'b0, 1'b0, r + 32'h4, pci_expansion_bus_bridge_pkg::RESP_DISC, 32'h0, 1'b0);
      pci(1'b1, 1'b0, r, c, 32'h0, 1'b0);
      pci_end();
      poll(32'h2ff, 32'h200);
      r = r ^ 32'h100;
      pci(1'b1, 1'b0, r, c, 32'h0, 1'b1);
      pci_end();
      poll(32'h2ff, 32'h200);
      c = pci_expansion_bus_bridge_pkg::RESP_ACK_DISC;
      pci(1'b1, 1'b0, r, c, {14'h0, r[19:2]} ^ PAT, 1'b0);
      c = pci_expansion_bus_bridge_pkg::RESP_NO_CLAIM;
      pci(1'b1, 1'b1, {win + 12'h1, 20'h0}, c, 32'h0, 1'b0);
      pci_end();
   endtask

   // ====
   // Main sequence: plain, clock output off, fast select after reset
   initial begin
      {rst, reg_write, reg_read, pv, pf, pw, fast, irq_n, slow} = 9'h102;
      {reg_addr, be, reg_wdata, pa, pd} = '0;
      for (int mode = 0; mode < 3; mode++) begin
         fast <= mode == 2;
         rst <= 1'b1;
         repeat (3) @(posedge clk_sys);
         rst <= 1'b0;
         reg_rd(4'h8, 33'h100000100);
         reg_rd(4'h2, 33'h100000000);
         pci(1'b1, 1'b1, 32'h0, pci_expansion_bus_bridge_pkg::RESP_NO_CLAIM, 32'h0, 1'b0);
         pci_end();
         win = 12'($random(seed));
         cfg = {mode != 1, 8'($random(seed))};
         reg_wr(4'h0, {win, 20'h0});
         reg_wr(4'h4, 32'h3);
         reg_wr(4'h8, {23'h0, cfg});
         reg_rd(4'h8, {10'h200, 14'h0, cfg});
         reg_rd(4'h0, {1'b1, win, 20'h0});
         slow <= mode == 1;
         irq_n <= 1'b0;
         traffic();
         irq_n <= 1'b1;
         poll(32'hff, 32'h0);
      end
      chk(36'(pq.size() + aq.size() + wq.size()), 36'h0);
      finish_test();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      finish_test();
   end

   // ====
   // Result monitor: each result meets the oldest note
   always @(posedge clk_sys) begin
      if (rd_d) begin
         rn = rq.pop_front();
         if (rn[32]) chk({4'h0, reg_rdata}, {4'h0, rn[31:0]});
      end
      if (rvalid) chk({1'b0, rcode, rdata}, {1'b0, pq.pop_front()});
      if (as_p && !as_n) chk({dout, ben}, aq.pop_front());
      if (wr_p && !wr_n) chk({4'h0, dout}, {4'h0, wq.pop_front()});
      rd_d <= reg_read;
      as_p <= as_n;
      wr_p <= wr_n;
   end
endmodule
`default_nettype wire
